// file: include/ocr_pkg.sv
`default_nettype none
package ocr_pkg;
  // Register offsets
  localparam logic [7:0] CHAN_A_CLOCK_SKEW_INVERT_OFS = 8'h17;
  localparam logic [7:0] CHAN_B_CLOCK_SKEW_INVERT_OFS = 8'h18;
  localparam logic [7:0] OVERLOAD_THRESHOLD_LEVEL_OFS = 8'h1F;

  // Values after reset
  localparam logic [7:0] CHAN_A_RESET = 8'h00;
  localparam logic [7:0] CHAN_B_RESET = 8'h00;
  localparam logic [7:0] OVERLOAD_RESET = 8'h7F;

  // Field positions
  localparam int DRIVE_BOOST_EN_BIT = 7;
  localparam int SKEW_LSB = 1;
  localparam int SKEW_MSB = 5;
  localparam int INVERT_BIT = 0;
  localparam int THRESH_MSB = 6;
  localparam int WO_TOP_BIT = 7;

  // Readable masks: write-only bits read as zero
  localparam logic [7:0] CHAN_A_READ_MASK = 8'hBF;
  localparam logic [7:0] CHAN_B_READ_MASK = 8'h3F;
  localparam logic [7:0] OVERLOAD_READ_MASK = 8'h7F;

  // Skew codes, earliest to latest clock position
  localparam logic [4:0] SKEW_M80 = 5'h05;
  localparam logic [4:0] SKEW_M55 = 5'h07;
  localparam logic [4:0] SKEW_ZERO = 5'h00;
  localparam logic [4:0] SKEW_P55 = 5'h0D;
  localparam logic [4:0] SKEW_P95 = 5'h0E;
  localparam logic [4:0] SKEW_P140 = 5'h0B;
  localparam logic [4:0] SKEW_P180 = 5'h14;
  localparam logic [4:0] SKEW_P230 = 5'h10;
  localparam logic [2:0] SKEW_ZERO_STEP = 3'h2;

  // Overload flag latency in output clock cycles
  localparam int OVERLOAD_LATENCY = 9;
  localparam logic [6:0] THRESH_FULL_SCALE = 7'h7F;

  typedef enum logic {QUAD_RATE, DOUBLE_RATE} ocr_rate_type;
endpackage
`default_nettype wire

// file: design/ocr_skew_dec.sv
`timescale 1ns/1ps
`default_nettype none
module ocr_skew_dec (
  input  wire logic       [4:0] i_code,
  output logic            [2:0] o_step,
  output logic signed     [8:0] o_delay_ps,
  output logic                  o_legal
);
  always_comb begin
    o_step     = ocr_pkg::SKEW_ZERO_STEP;
    o_delay_ps = 9'sh000;
    o_legal    = 1'b1;
    unique case (i_code)
      ocr_pkg::SKEW_M80: begin
        o_step     = 3'h0;
        o_delay_ps = -9'sh050;
      end
      ocr_pkg::SKEW_M55: begin
        o_step     = 3'h1;
        o_delay_ps = -9'sh037;
      end
      ocr_pkg::SKEW_ZERO: begin
        o_step     = 3'h2;
        o_delay_ps = 9'sh000;
      end
      ocr_pkg::SKEW_P55: begin
        o_step     = 3'h3;
        o_delay_ps = 9'sh037;
      end
      ocr_pkg::SKEW_P95: begin
        o_step     = 3'h4;
        o_delay_ps = 9'sh05F;
      end
      ocr_pkg::SKEW_P140: begin
        o_step     = 3'h5;
        o_delay_ps = 9'sh08C;
      end
      ocr_pkg::SKEW_P180: begin
        o_step     = 3'h6;
        o_delay_ps = 9'sh0B4;
      end
      ocr_pkg::SKEW_P230: begin
        o_step     = 3'h7;
        o_delay_ps = 9'sh0E6;
      end
      // Undefined codes fall back to the unshifted position
      default: begin
        o_legal = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: design/ocr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Clock drive boost applies only while the boost enable bit is one.
// - Channel A skew field shifts channel A output clock against data.
// - Skew field holds eight defined codes; zero code means no shift.
// - Channel A clock inverts in quad-rate mode with override set.
// - Channel B skew field shifts channel B clock with same codes.
// - Channel B clock inverts in quad-rate mode with override set.
// - Double-rate mode: channel B invert bit inverts the shared clock.
// - Threshold register resets to 7Fh; top bit is write-only.
// - Overload flag rises nine output clocks after input exceeds threshold.
// - Rate select zero gives quad-rate, one gives double-rate mode.
module ocr_regs #(
  parameter int LATENCY = ocr_pkg::OVERLOAD_LATENCY
) (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic        [7:0] i_reg_addr,
  input  wire logic        [7:0] i_reg_wdata,
  input  wire logic              i_output_rate_select,
  input  wire logic              i_control_pin_override,
  input  wire logic              i_clk_strength_bit,
  input  wire logic              i_out_clk_en,
  input  wire logic        [6:0] i_input_level,
  output logic             [7:0] o_reg_rdata,
  output logic                   o_reg_rvalid,
  output logic                   o_clk_drive_boost,
  output logic             [2:0] o_skew_step_a,
  output logic signed      [8:0] o_skew_ps_a,
  output logic             [2:0] o_skew_step_b,
  output logic signed      [8:0] o_skew_ps_b,
  output logic                   o_skew_code_illegal,
  output logic                   o_invert_a,
  output logic                   o_invert_b,
  output logic                   o_invert_shared,
  output logic             [6:0] o_overload_threshold,
  output logic                   o_fast_overload
);
  logic [7:0] chan_a_reg;
  logic [7:0] chan_b_reg;
  logic [7:0] overload_reg;
  logic [7:0] chan_a_next;
  logic [7:0] chan_b_next;
  logic [7:0] overload_next;
  logic [LATENCY-1:0] over_pipe_reg;

  // Address decode
  wire hit_a = i_reg_addr == ocr_pkg::CHAN_A_CLOCK_SKEW_INVERT_OFS;
  wire hit_b = i_reg_addr == ocr_pkg::CHAN_B_CLOCK_SKEW_INVERT_OFS;
  wire hit_o = i_reg_addr == ocr_pkg::OVERLOAD_THRESHOLD_LEVEL_OFS;

  assign chan_a_next   = (i_reg_wr && hit_a) ? i_reg_wdata : chan_a_reg;
  assign chan_b_next   = (i_reg_wr && hit_b) ? i_reg_wdata : chan_b_reg;
  assign overload_next = (i_reg_wr && hit_o) ? i_reg_wdata : overload_reg;

  // Write-only bits read back as zero, unmapped offsets read zero
  wire [7:0] read_mux =
    hit_a ? (chan_a_reg & ocr_pkg::CHAN_A_READ_MASK) :
    hit_b ? (chan_b_reg & ocr_pkg::CHAN_B_READ_MASK) :
    hit_o ? (overload_reg & ocr_pkg::OVERLOAD_READ_MASK) : 8'h00;

  wire ocr_pkg::ocr_rate_type rate =
    i_output_rate_select ? ocr_pkg::DOUBLE_RATE : ocr_pkg::QUAD_RATE;
  wire quad = rate == ocr_pkg::QUAD_RATE;

  wire [4:0] code_a = chan_a_reg[ocr_pkg::SKEW_MSB:ocr_pkg::SKEW_LSB];
  wire [4:0] code_b = chan_b_reg[ocr_pkg::SKEW_MSB:ocr_pkg::SKEW_LSB];
  wire [2:0] step_a;
  wire [2:0] step_b;
  wire signed [8:0] ps_a;
  wire signed [8:0] ps_b;
  wire legal_a;
  wire legal_b;

  ocr_skew_dec u_dec_a (
    .i_code     (code_a),
    .o_step     (step_a),
    .o_delay_ps (ps_a),
    .o_legal    (legal_a)
  );

  ocr_skew_dec u_dec_b (
    .i_code     (code_b),
    .o_step     (step_b),
    .o_delay_ps (ps_b),
    .o_legal    (legal_b)
  );

  wire boost = chan_a_reg[ocr_pkg::DRIVE_BOOST_EN_BIT] & i_clk_strength_bit;
  wire inv_a = quad & i_control_pin_override & chan_a_reg[ocr_pkg::INVERT_BIT];
  wire inv_b = quad & i_control_pin_override & chan_b_reg[ocr_pkg::INVERT_BIT];
  // Shared clock inversion, no override needed
  wire inv_s = !quad & chan_b_reg[ocr_pkg::INVERT_BIT];

  // Input above full scale times threshold over 127
  wire over_now = i_input_level > overload_reg[ocr_pkg::THRESH_MSB:0];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      chan_a_reg   <= ocr_pkg::CHAN_A_RESET;
      chan_b_reg   <= ocr_pkg::CHAN_B_RESET;
      overload_reg <= ocr_pkg::OVERLOAD_RESET;
    end else begin
      chan_a_reg   <= chan_a_next;
      chan_b_reg   <= chan_b_next;
      overload_reg <= overload_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rdata  <= i_reg_rd ? read_mux : o_reg_rdata;
      o_reg_rvalid <= i_reg_rd;
    end
  end

  // Outputs are registered copies so the pad logic sees no decode glitches
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_clk_drive_boost    <= 1'b0;
      o_skew_step_a        <= ocr_pkg::SKEW_ZERO_STEP;
      o_skew_ps_a          <= 9'sh000;
      o_skew_step_b        <= ocr_pkg::SKEW_ZERO_STEP;
      o_skew_ps_b          <= 9'sh000;
      o_skew_code_illegal  <= 1'b0;
      o_invert_a           <= 1'b0;
      o_invert_b           <= 1'b0;
      o_invert_shared      <= 1'b0;
      o_overload_threshold <= ocr_pkg::THRESH_FULL_SCALE;
    end else begin
      o_clk_drive_boost    <= boost;
      o_skew_step_a        <= step_a;
      o_skew_ps_a          <= ps_a;
      o_skew_step_b        <= step_b;
      o_skew_ps_b          <= ps_b;
      o_skew_code_illegal  <= !legal_a | !legal_b;
      o_invert_a           <= inv_a;
      o_invert_b           <= inv_b;
      o_invert_shared      <= inv_s;
      o_overload_threshold <= overload_reg[ocr_pkg::THRESH_MSB:0];
    end
  end

  // Latency pipe advanced on each output clock
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      over_pipe_reg <= '0;
    end else if (i_out_clk_en) begin
      over_pipe_reg <= {over_pipe_reg[LATENCY-2:0], over_now};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_fast_overload <= 1'b0;
    end else begin
      o_fast_overload <= over_pipe_reg[LATENCY-1];
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_boost_gate_off: assert property (
    !chan_a_reg[ocr_pkg::DRIVE_BOOST_EN_BIT] |=> !o_clk_drive_boost)
    else $error("drive boost active while enable bit is zero");

  a_skew_a_follow: assert property (
    (i_reg_wr && hit_a && i_reg_wdata[5:1] == ocr_pkg::SKEW_P230)
      |-> ##2 (o_skew_step_a == 3'h7 && o_skew_ps_a == 9'sh0E6))
    else $error("channel A skew did not follow written code");

  a_skew_zero_code: assert property (
    (code_a == ocr_pkg::SKEW_ZERO) |=> (o_skew_step_a == ocr_pkg::SKEW_ZERO_STEP
      && o_skew_ps_a == 9'sh000))
    else $error("zero skew code did not give zero shift");

  a_invert_a_cond: assert property (
    !(quad && i_control_pin_override) |=> !o_invert_a)
    else $error("channel A inverted outside quad-rate override");

  a_skew_b_early: assert property (
    (code_b == ocr_pkg::SKEW_M80) |=> (o_skew_ps_b == -9'sh050 && o_skew_step_b == 3'h0))
    else $error("channel B skew code decode wrong");

  a_invert_b_cond: assert property (
    (quad && i_control_pin_override && chan_b_reg[0]) |=> (o_invert_b && !o_invert_shared))
    else $error("channel B quad-rate inversion missing");

  a_shared_invert: assert property (
    (!quad && chan_b_reg[0]) |=> (o_invert_shared && !o_invert_b))
    else $error("shared clock inversion missing in double-rate mode");

  a_thresh_readback: assert property (
    (i_reg_rd && hit_o) |=> (o_reg_rdata[ocr_pkg::WO_TOP_BIT] == 1'b0
      && o_reg_rdata[6:0] == o_overload_threshold))
    else $error("threshold readback wrong or write-only bit visible");

  a_overload_delay: assert property (
    (i_out_clk_en && over_now && !over_pipe_reg[0]) |=> over_pipe_reg[0])
    else $error("overload pipe did not capture exceedance");

  a_overload_out: assert property (
    over_pipe_reg[LATENCY-1] |=> o_fast_overload)
    else $error("overload flag not raised at end of latency");
endmodule
`default_nettype wire

// file: test/ocr_capture_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocr_capture_model (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_slow,
  output logic      o_out_clk_en
);
  logic [1:0] div_reg;
  logic [1:0] div_next;
  // Slow capture side takes one word clock in three, so the latency is counted in enables
  assign div_next = (i_slow && div_reg != 2'h2) ? div_reg + 2'h1 : 2'h0;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_next;
    end
  end
  assign o_out_clk_en = !i_sys_rst && (!i_slow || div_reg == 2'h2);
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int LAT = 9;
  logic             i_clk = 1'b0;
  logic             i_sys_rst = 1'b1;
  logic             wr = 1'b0, rd = 1'b0, rsel = 1'b0, ovr = 1'b0, strength = 1'b0, slow = 1'b0;
  logic       [7:0] addr = 8'h00, wdata = 8'h00;
  logic       [6:0] level = 7'h00, thr, t;
  logic       [7:0] rdata;
  logic             en, rvalid, boost, ill, inv_a, inv_b, inv_s, fovr;
  logic       [2:0] step_a, step_b;
  logic       [8:0] ps_a, ps_b;
  logic       [7:0] rd_q[$];
  int               fails = 0;
  int               checked = 0;
  logic       [4:0] codes[8] = '{5'h05, 5'h07, 5'h00, 5'h0D, 5'h0E, 5'h0B, 5'h14, 5'h10};
  logic       [8:0] pss[8] = '{9'h1B0, 9'h1C9, 9'h000, 9'h037, 9'h05F, 9'h08C, 9'h0B4, 9'h0E6};

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  ocr_regs #(.LATENCY(LAT)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_output_rate_select(rsel),
    .i_control_pin_override(ovr), .i_clk_strength_bit(strength), .i_out_clk_en(en),
    .i_input_level(level), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_clk_drive_boost(boost), .o_skew_step_a(step_a), .o_skew_ps_a(ps_a),
    .o_skew_step_b(step_b), .o_skew_ps_b(ps_b), .o_skew_code_illegal(ill),
    .o_invert_a(inv_a), .o_invert_b(inv_b), .o_invert_shared(inv_s),
    .o_overload_threshold(thr), .o_fast_overload(fovr));
  ocr_capture_model far_end (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_slow(slow),
    .o_out_clk_en(en));

  task automatic chk(input string what, input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge i_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    rd <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  task automatic wait_en(input int n);
    repeat (n) begin
      @(posedge i_clk);
      while (en !== 1'b1) @(posedge i_clk);
    end
    #1;
  endtask

  task automatic end_sim();
    // A read that never came back counts against the run
    if (rd_q.size() != 0) fails++;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Read answers pair with the oldest noted expectation
  always @(posedge i_clk) begin
    if (rvalid === 1'b1) begin
      if (rd_q.size() == 0) begin
        chk("rvalid", 9'h001, 9'h000);
      end else begin
        chk("rdata", {1'h0, rdata}, {1'h0, rd_q.pop_front()});
      end
    end
  end

  initial begin
    #(40 * 20000);
    fails++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hCB9C));
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    reg_rd(8'h17, 8'h00);
    reg_rd(8'h18, 8'h00);
    reg_rd(8'h1F, 8'h7F);
    reg_rd(8'h20, 8'h00);
    settle();
    chk("threshold", {2'h0, thr}, 9'h07F);
    chk("step_a", {6'h00, step_a}, 9'h002);
    for (int i = 0; i < 8; i++) begin
      reg_wr(8'h17, {2'h0, codes[i], 1'h0});
      reg_wr(8'h18, {2'h0, codes[7 - i], 1'h0});
      reg_rd(8'h17, {2'h0, codes[i], 1'h0});
      settle();
      chk("step_a", {6'h00, step_a}, 9'(i));
      chk("ps_a", ps_a, pss[i]);
      chk("step_b", {6'h00, step_b}, 9'(7 - i));
      chk("ps_b", ps_b, pss[7 - i]);
      chk("illegal", {8'h00, ill}, 9'h000);
    end
    reg_wr(8'h17, 8'h02);
    settle();
    chk("illegal", {8'h00, ill}, 9'h001);
    chk("step_a", {6'h00, step_a}, 9'h002);
    for (int b = 0; b < 4; b++) begin
      @(posedge i_clk);
      strength <= b[0];
      reg_wr(8'h17, {b[1], 7'h00});
      settle();
      chk("boost", {8'h00, boost}, {8'h00, b[1] & b[0]});
    end
    for (int m = 0; m < 8; m++) begin
      @(posedge i_clk);
      rsel <= m[2];
      ovr <= m[1];
      reg_wr(8'h17, {7'h00, m[0]});
      reg_wr(8'h18, {7'h00, m[0]});
      settle();
      chk("invert_a", {8'h00, inv_a}, {8'h00, !m[2] & m[1] & m[0]});
      chk("invert_b", {8'h00, inv_b}, {8'h00, !m[2] & m[1] & m[0]});
      chk("invert_shared", {8'h00, inv_s}, {8'h00, m[2] & m[0]});
    end
    // Write-only bits stay zero; channel A gets defined skew code 14h, channel B defined code 10h
    reg_wr(8'h17, 8'hA9);
    reg_wr(8'h18, 8'h21);
    reg_wr(8'h1F, 8'h7F);
    reg_rd(8'h17, 8'hA9);
    reg_rd(8'h18, 8'h21);
    reg_rd(8'h1F, 8'h7F);
    for (int s = 0; s < 2; s++) begin
      // Level parked at zero so a stale level cannot preload the pipe
      @(posedge i_clk);
      slow <= s[0];
      level <= 7'h00;
      t = 7'($urandom_range(1, 125));
      reg_wr(8'h1F, {1'h0, t});
      settle();
      chk("threshold", {2'h0, thr}, {2'h0, t});
      @(posedge i_clk);
      level <= t + 7'h01;
      wait_en(LAT);
      chk("overload_early", {8'h00, fovr}, 9'h000);
      @(posedge i_clk);
      #1;
      chk("overload", {8'h00, fovr}, 9'h001);
      @(posedge i_clk);
      level <= t;
      wait_en(LAT + 3);
      chk("overload_equal", {8'h00, fovr}, 9'h000);
    end
    settle();
    end_sim();
  end
endmodule
`default_nettype wire
